// >>> rtl/ess_store_seq.sv
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
// What this block does
// - data instruction byte N moves N plus one bytes
// - two bytes after a data instruction form the 16-bit map start address
// - write the instruction byte to EEPROM first, pointer plus one
// - then write both address bytes, pointer plus two
// - then copy count bytes from consecutive map addresses, pointer plus count
// - slot 0x0E55 defaults to five bytes from 0x0A40
// - slot 0x0E58 defaults to five bytes from 0x0A60
// - slot 0x0E5B defaults to 0x04, five bytes from 0x0A80
// - end writes byte plus CRC-32, pointer to zero; pause advances pointer
module ess_store_seq
    import ess_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // avalon-mm register slave
    input  wire logic [13:0] AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // register map read port
    output logic             MAP_RD,
    output logic [15:0]      MAP_ADDR,
    input  wire logic        MAP_ACK,
    input  wire logic [7:0]  MAP_DATA,
    // eeprom byte stream out
    output logic             EE_VALID,
    input  wire logic        EE_READY,
    output logic [15:0]      EE_ADDR,
    output logic [7:0]       EE_DATA
);
    // sequence slots, packed one byte each
    logic [7:0]       slot [SLOT_COUNT];
    logic [7:0]       next_slot [SLOT_COUNT];
    ess_state_t       state;
    ess_state_t       next_state;
    logic [3:0]       sidx;
    logic [3:0]       next_sidx;
    logic [7:0]       instr;
    logic [7:0]       next_instr;
    logic [8:0]       remain;
    logic [8:0]       next_remain;
    logic [15:0]      map_ptr;
    logic [15:0]      next_map_ptr;
    logic [15:0]      ee_ptr;
    logic [15:0]      next_ee_ptr;
    logic [31:0]      crc;
    logic [31:0]      next_crc;
    logic [2:0]       crc_cnt;
    logic [2:0]       next_crc_cnt;
    logic             done;
    logic             next_done;
    logic             map_rd;
    logic             next_map_rd;
    logic [31:0]      rdata;
    logic [31:0]      next_rdata;
    logic             wait_q;
    logic             next_wait_q;
    logic             waitreq;
    logic             next_waitreq;
    logic             start;
    logic [11:0]      reg_idx;
    logic             push;
    logic [7:0]       push_byte;
    logic             f_ready;
    logic             f_valid;
    logic [23:0]      f_data;
    logic             ee_valid;
    logic             next_ee_valid;
    logic [23:0]      ee_word;
    logic [23:0]      next_ee_word;

    assign reg_idx = AVS_ADDRESS[13:2];

    // crc-32 update of one byte, lsb first
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h000000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    // bus slave: one wait cycle, answer on second edge
    always_comb begin
        next_wait_q = 1'b0;
        next_rdata  = rdata;
        start       = 1'b0;
        for (int i = 0; i < SLOT_COUNT; i++) begin
            next_slot[i] = slot[i];
        end
        if ((AVS_READ || AVS_WRITE) && wait_q) begin
            next_wait_q = 1'b0;
        end else if (AVS_READ || AVS_WRITE) begin
            next_wait_q = 1'b1;
        end
        next_waitreq = !next_wait_q; // low only on the accept cycle
        if (AVS_READ && !wait_q) begin
            next_rdata = 32'h00000000;
            if (reg_idx >= SLOT_U1_INSTR && reg_idx < SLOT_U1_INSTR + 12'(SLOT_COUNT)) begin
                next_rdata[7:0] = slot[4'(reg_idx - SLOT_U1_INSTR)];
            end else if (reg_idx == REG_STATUS) begin
                next_rdata[STAT_BUSY_BIT] = (state != ESS_IDLE);
                next_rdata[STAT_DONE_BIT] = done;
            end else if (reg_idx == REG_PTR_LO) begin
                next_rdata[7:0] = ee_ptr[7:0];
            end else if (reg_idx == REG_PTR_HI) begin
                next_rdata[7:0] = ee_ptr[15:8];
            end
        end
        if (AVS_WRITE && wait_q && AVS_BYTEENABLE[0]) begin
            if (reg_idx >= SLOT_U1_INSTR && reg_idx < SLOT_U1_INSTR + 12'(SLOT_COUNT)
                    && state == ESS_IDLE) begin
                next_slot[4'(reg_idx - SLOT_U1_INSTR)] = AVS_WRITEDATA[7:0];
            end else if (reg_idx == REG_CTRL) begin
                start = AVS_WRITEDATA[CTRL_START_BIT];
            end
        end
    end

    // bus slave and slot registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wait_q  <= 1'b0;
            waitreq <= 1'b1;
            rdata   <= 32'h00000000;
            slot[0] <= RST_U1_INSTR;
            slot[1] <= RST_U1_ADDR_A;
            slot[2] <= RST_U1_ADDR_B;
            slot[3] <= RST_U2_INSTR;
            slot[4] <= RST_U2_ADDR_A;
            slot[5] <= RST_U2_ADDR_B;
            slot[6] <= RST_U3_INSTR;
            slot[7] <= RST_U3_ADDR_A;
            slot[8] <= RST_U3_ADDR_B;
            slot[9] <= RST_END;
        end else begin
            wait_q <= next_wait_q;
            waitreq <= next_waitreq;
            rdata  <= next_rdata;
            for (int i = 0; i < SLOT_COUNT; i++) begin
                slot[i] <= next_slot[i];
            end
        end
    end

    // sequencer next state
    always_comb begin
        next_state   = state;
        next_sidx    = sidx;
        next_instr   = instr;
        next_remain  = remain;
        next_map_ptr = map_ptr;
        next_ee_ptr  = ee_ptr;
        next_crc     = crc;
        next_crc_cnt = crc_cnt;
        next_done    = done;
        next_map_rd  = 1'b0;
        push         = 1'b0;
        push_byte    = 8'h00;
        case (state)
            ESS_IDLE: begin
                if (start) begin
                    next_sidx  = 4'h0;
                    next_crc   = CRC_INIT;
                    next_done  = 1'b0;
                    next_state = ESS_FETCH;
                end
            end
            ESS_FETCH: begin
                if (sidx >= 4'(SLOT_COUNT)) begin
                    next_state = ESS_FINISH; // runaway sequence stops here
                end else begin
                    next_instr = slot[sidx];
                    next_state = ESS_DECODE;
                end
            end
            ESS_DECODE: begin
                if (f_ready) begin
                    push      = 1'b1;
                    push_byte = instr;
                    next_ee_ptr = ee_ptr + 16'h0001;
                    next_crc  = crc_byte(crc, instr);
                    next_sidx = sidx + 4'h1;
                    if (instr == INSTR_END || instr == INSTR_PAUSE) begin
                        next_crc_cnt = 3'h0;
                        next_state   = ESS_CRC;
                    end else if (instr <= INSTR_DATA_MAX) begin
                        next_remain = {1'b0, instr} + 9'h001;
                        next_state  = ESS_ADDR_A;
                    end else begin
                        next_state = ESS_FETCH;
                    end
                end
            end
            ESS_ADDR_A, ESS_ADDR_B: begin
                if (f_ready) begin
                    push        = 1'b1;
                    push_byte   = slot[sidx];
                    next_ee_ptr = ee_ptr + 16'h0001;
                    next_crc    = crc_byte(crc, slot[sidx]);
                    next_sidx   = sidx + 4'h1;
                    if (state == ESS_ADDR_A) begin
                        next_map_ptr[15:8] = slot[sidx];
                        next_state         = ESS_ADDR_B;
                    end else begin
                        next_map_ptr[7:0] = slot[sidx];
                        next_state        = ESS_MAPREQ;
                    end
                end
            end
            ESS_MAPREQ: begin
                if (f_ready) begin
                    next_map_rd = 1'b1;
                    next_state  = ESS_MAPWAIT;
                end
            end
            ESS_MAPWAIT: begin
                next_map_rd = map_rd && !MAP_ACK;
                if (MAP_ACK) begin
                    push         = 1'b1;
                    push_byte    = MAP_DATA;
                    next_ee_ptr  = ee_ptr + 16'h0001;
                    next_map_ptr = map_ptr + 16'h0001;
                    next_crc     = crc_byte(crc, MAP_DATA);
                    next_remain  = remain - 9'h001;
                    next_state   = (remain == 9'h001) ? ESS_FETCH : ESS_MAPREQ;
                end
            end
            ESS_CRC: begin
                if (f_ready) begin
                    push         = 1'b1;
                    push_byte    = ~crc[8*crc_cnt[1:0] +: 8];
                    next_ee_ptr  = ee_ptr + 16'h0001;
                    next_crc_cnt = crc_cnt + 3'h1;
                    if (crc_cnt == 3'(CRC_BYTES - 1)) begin
                        next_state = ESS_FINISH;
                    end
                end
            end
            ESS_FINISH: begin
                if (instr == INSTR_END) begin
                    next_ee_ptr = 16'h0000;
                end
                next_done  = 1'b1;
                next_state = ESS_IDLE;
            end
            default: begin
                next_state = ESS_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state   <= ESS_IDLE;
            sidx    <= 4'h0;
            instr   <= 8'h00;
            remain  <= 9'h000;
            map_ptr <= 16'h0000;
            ee_ptr  <= 16'h0000;
            crc     <= CRC_INIT;
            crc_cnt <= 3'h0;
            done    <= 1'b0;
            map_rd  <= 1'b0;
        end else begin
            state   <= next_state;
            sidx    <= next_sidx;
            instr   <= next_instr;
            remain  <= next_remain;
            map_ptr <= next_map_ptr;
            ee_ptr  <= next_ee_ptr;
            crc     <= next_crc;
            crc_cnt <= next_crc_cnt;
            done    <= next_done;
            map_rd  <= next_map_rd;
        end
    end

    // byte buffer toward the eeprom writer, tagged with its eeprom address
    ess_fifo #(
        .WIDTH (24),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (CLK),
        .rst_n     (RST_N),
        .in_valid  (push),
        .in_ready  (f_ready),
        .in_data   ({ee_ptr, push_byte}),
        .out_valid (f_valid),
        .out_ready (!ee_valid || EE_READY),
        .out_data  (f_data)
    );

    // registered output stage
    always_comb begin
        next_ee_valid = ee_valid;
        next_ee_word  = ee_word;
        if (!ee_valid || EE_READY) begin
            next_ee_valid = f_valid;
            next_ee_word  = f_data;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ee_valid <= 1'b0;
            ee_word  <= 24'h000000;
        end else begin
            ee_valid <= next_ee_valid;
            ee_word  <= next_ee_word;
        end
    end

    assign AVS_READDATA    = rdata;
    assign AVS_WAITREQUEST = waitreq;
    assign MAP_RD          = map_rd;
    assign MAP_ADDR        = map_ptr;
    assign EE_VALID        = ee_valid;
    assign EE_ADDR         = ee_word[23:8];
    assign EE_DATA         = ee_word[7:0];
endmodule // ess_store_seq

// >>> rtl/ess_pkg.sv
package ess_pkg;
    // sequence slot byte addresses (register index = slot address, byte address = 4x)
    localparam logic [11:0] SLOT_U1_INSTR   = 12'hE55;
    localparam logic [11:0] SLOT_U1_ADDR_A  = 12'hE56;
    localparam logic [11:0] SLOT_U1_ADDR_B  = 12'hE57;
    localparam logic [11:0] SLOT_U2_INSTR   = 12'hE58;
    localparam logic [11:0] SLOT_U2_ADDR_A  = 12'hE59;
    localparam logic [11:0] SLOT_U2_ADDR_B  = 12'hE5A;
    localparam logic [11:0] SLOT_U3_INSTR   = 12'hE5B;
    localparam logic [11:0] SLOT_U3_ADDR_A  = 12'hE5C;
    localparam logic [11:0] SLOT_U3_ADDR_B  = 12'hE5D;
    localparam logic [11:0] SLOT_END        = 12'hE5E;
    localparam int          SLOT_COUNT      = 10;
    // control and status registers
    localparam logic [11:0] REG_CTRL        = 12'hE70;
    localparam logic [11:0] REG_STATUS      = 12'hE71;
    localparam logic [11:0] REG_PTR_LO      = 12'hE72;
    localparam logic [11:0] REG_PTR_HI      = 12'hE73;
    localparam int          CTRL_START_BIT  = 0;
    localparam int          STAT_BUSY_BIT   = 0;
    localparam int          STAT_DONE_BIT   = 1;
    // slot reset values
    localparam logic [7:0]  RST_U1_INSTR    = 8'h04;
    localparam logic [7:0]  RST_U1_ADDR_A   = 8'h0A;
    localparam logic [7:0]  RST_U1_ADDR_B   = 8'h40;
    localparam logic [7:0]  RST_U2_INSTR    = 8'h04;
    localparam logic [7:0]  RST_U2_ADDR_A   = 8'h0A;
    localparam logic [7:0]  RST_U2_ADDR_B   = 8'h60;
    localparam logic [7:0]  RST_U3_INSTR    = 8'h04;
    localparam logic [7:0]  RST_U3_ADDR_A   = 8'h0A;
    localparam logic [7:0]  RST_U3_ADDR_B   = 8'h80;
    localparam logic [7:0]  RST_END         = 8'hFF;
    // instruction encodings
    localparam logic [7:0]  INSTR_END       = 8'hFF;
    localparam logic [7:0]  INSTR_PAUSE     = 8'hFE;
    localparam logic [7:0]  INSTR_DATA_MAX  = 8'h7F;
    localparam int          CRC_BYTES       = 4;
    localparam logic [31:0] CRC_POLY        = 32'hEDB88320;
    localparam logic [31:0] CRC_INIT        = 32'hFFFFFFFF;
    localparam int          FIFO_DEPTH      = 8;
    localparam int          EE_ADDR_W       = 16;

    typedef enum logic [9:0] {
        ESS_IDLE    = 10'b0000000001,
        ESS_FETCH   = 10'b0000000010,
        ESS_DECODE  = 10'b0000000100,
        ESS_ADDR_A  = 10'b0000001000,
        ESS_ADDR_B  = 10'b0000010000,
        ESS_MAPREQ  = 10'b0000100000,
        ESS_MAPWAIT = 10'b0001000000,
        ESS_CRC     = 10'b0010000000,
        ESS_SKIP    = 10'b0100000000,
        ESS_FINISH  = 10'b1000000000
    } ess_state_t;
endpackage

// >>> rtl/ess_fifo.sv
`timescale 1ns/1ns
module ess_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    // handshake and pointer arithmetic
    always_comb begin
        push        = in_valid && (count != (AW+1)'(DEPTH));
        pop         = (count != '0) && out_ready;
        next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1)) : wr_ptr;
        next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1)) : rd_ptr;
        next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    // pointer registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // storage, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
endmodule // ess_fifo

// >>> test/ess_store_seq_chk.sv
`timescale 1ns/1ns
module ess_store_seq_chk (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RST_N,
    // register slave
    input wire logic [13:0] AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    // map read port
    input wire logic        MAP_RD,
    input wire logic [15:0] MAP_ADDR,
    input wire logic        MAP_ACK,
    input wire logic [7:0]  MAP_DATA,
    // eeprom stream
    input wire logic        EE_VALID,
    input wire logic        EE_READY,
    input wire logic [15:0] EE_ADDR,
    input wire logic [7:0]  EE_DATA
);
    logic [15:0] last_addr;
    logic        have_last;

    // address of the previous accepted eeprom byte
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            have_last <= 1'b0;
            last_addr <= 16'h0000;
        end else if (EE_VALID && EE_READY) begin
            have_last <= 1'b1;
            last_addr <= EE_ADDR;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    property p_wait_first;
        $rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("new request not stalled");
    property p_wait_one;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("more than one wait cycle");
    property p_idle;
        !(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST;
    endproperty
    a_idle: assert property (p_idle) else $error("accept without request");
    property p_rd_upper;
        AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h000000;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
    property p_rd_stand;
        !AVS_READ |=> $stable(AVS_READDATA);
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data moved without read");
    property p_ee_hold;
        EE_VALID && !EE_READY |=> EE_VALID && $stable(EE_DATA) && $stable(EE_ADDR);
    endproperty
    a_ee_hold: assert property (p_ee_hold) else $error("stream byte dropped in stall");
    property p_map_hold;
        MAP_RD && !MAP_ACK |=> MAP_RD && $stable(MAP_ADDR);
    endproperty
    a_map_hold: assert property (p_map_hold) else $error("map read not held");
    property p_ee_addr;
        EE_VALID && EE_READY && have_last |->
            (EE_ADDR == last_addr + 16'h0001) || (EE_ADDR == 16'h0000);
    endproperty
    a_ee_addr: assert property (p_ee_addr) else $error("pointer skipped");
    property p_rst_quiet;
        $rose(RST_N) |-> !EE_VALID && !MAP_RD;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("activity out of reset");

    // main scenarios
    c_stall: cover property (EE_VALID && !EE_READY);
    c_ack: cover property (MAP_ACK);
    c_end: cover property (EE_VALID && EE_READY && EE_DATA == 8'hFF);
endmodule // ess_store_seq_chk

bind ess_store_seq ess_store_seq_chk i_chk (
    .CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .MAP_RD(MAP_RD),
    .MAP_ADDR(MAP_ADDR), .MAP_ACK(MAP_ACK), .MAP_DATA(MAP_DATA), .EE_VALID(EE_VALID),
    .EE_READY(EE_READY), .EE_ADDR(EE_ADDR), .EE_DATA(EE_DATA)
);

// >>> test/ess_far_model.sv
`timescale 1ns/1ns
module ess_far_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register map side
    input  wire logic        map_rd,
    input  wire logic [15:0] map_addr,
    output logic             map_ack,
    output logic [7:0]       map_data,
    // eeprom side
    output logic             ee_ready
);
    logic [1:0] wait_cnt;
    logic [5:0] tick;

    // map answers after 0 to 3 extra cycles; data churns while idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            map_ack  <= 1'b0;
            map_data <= 8'h00;
            wait_cnt <= 2'h0;
        end else begin
            map_ack <= 1'b0;
            if (map_rd && !map_ack && wait_cnt == map_addr[1:0]) begin
                map_ack  <= 1'b1;
                map_data <= map_addr[7:0] ^ map_addr[15:8] ^ 8'h5A;
                wait_cnt <= 2'h0;
            end else if (map_rd && !map_ack) begin
                wait_cnt <= wait_cnt + 2'h1;
            end else begin
                map_data <= ~map_data;
            end
        end
    end

    // eeprom takes bytes with short stalls and a long one every 64 cycles
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick     <= 6'h00;
            ee_ready <= 1'b0;
        end else begin
            tick     <= tick + 6'h01;
            ee_ready <= (tick < 6'd44) && (tick % 6'd3 != 6'd2);
        end
    end
endmodule // ess_far_model

// >>> test/eeprom_store_sequence_pll_ops_test.sv
`timescale 1ns/1ns
module eeprom_store_sequence_pll_ops_test;
    import ess_pkg::*;
    logic        clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic        map_rd, map_ack, ee_valid, ee_ready;
    logic [13:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [15:0] map_addr, ee_addr, ptr_now;
    logic [7:0]  map_data, ee_data;
    logic [7:0]  slot [SLOT_COUNT];
    logic [23:0] exp_q [$];
    logic [23:0] got_q [$];
    int          error_cnt, n_tests;

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ess_store_seq i_dut (
        .CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .MAP_RD(map_rd),
        .MAP_ADDR(map_addr), .MAP_ACK(map_ack), .MAP_DATA(map_data), .EE_VALID(ee_valid),
        .EE_READY(ee_ready), .EE_ADDR(ee_addr), .EE_DATA(ee_data)
    );
    ess_far_model i_far (
        .clk(clk), .rst_n(rst_n), .map_rd(map_rd), .map_addr(map_addr), .map_ack(map_ack),
        .map_data(map_data), .ee_ready(ee_ready)
    );

    // record every byte the eeprom accepts
    always @(posedge clk) begin
        if (rst_n && ee_valid && ee_ready) begin
            got_q.push_back({ee_addr, ee_data});
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic xfer(input logic wr, input logic [11:0] idx, input logic [7:0] wd,
                        output logic [31:0] rd);
        @(posedge clk);
        avs_address   <= {idx, 2'b00};
        avs_writedata <= {24'h000000, wd};
        avs_write     <= wr;
        avs_read      <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        xfer(1'b0, idx, 8'h00, rd);
        check(rd, {24'h000000, exp});
    endtask

    task automatic wr_slot(input int i, input logic [7:0] v);
        logic [31:0] rd;
        slot[i] = v;
        xfer(1'b1, SLOT_U1_INSTR + 12'(i), v, rd);
    endtask

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        c = c ^ {24'h000000, b};
        for (int k = 0; k < 8; k++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    function automatic void put(inout logic [15:0] p, inout logic [31:0] c,
                                input logic [7:0] b);
        exp_q.push_back({p, b});
        c = crc_byte(c, b);
        p = p + 16'h0001;
    endfunction

    // expected stream from the slot mirror, starting at pointer p
    function automatic void build(input logic [15:0] p, output logic [15:0] fin);
        logic [31:0] c;
        logic [15:0] a;
        int          i;
        c = CRC_INIT;
        i = 0;
        fin = p;
        exp_q.delete();
        while (i < SLOT_COUNT) begin
            put(p, c, slot[i]);
            if (slot[i] <= INSTR_DATA_MAX) begin
                a = {slot[i+1], slot[i+2]};
                put(p, c, slot[i+1]);
                put(p, c, slot[i+2]);
                for (int k = 0; k <= int'(slot[i]); k++) begin
                    put(p, c, a[7:0] ^ a[15:8] ^ 8'h5A);
                    a = a + 16'h0001;
                end
                i = i + 3;
            end else if (slot[i] == INSTR_END || slot[i] == INSTR_PAUSE) begin
                c = ~c;
                for (int k = 0; k < CRC_BYTES; k++) begin
                    exp_q.push_back({p, c[8*k +: 8]});
                    p = p + 16'h0001;
                end
                fin = (slot[i] == INSTR_END) ? 16'h0000 : p;
                return;
            end else begin
                i = i + 1;
            end
        end
    endfunction

    // start a store, optionally poke a slot while busy, compare stream
    task automatic run_seq(input logic poke);
        logic [31:0] rd;
        logic [15:0] fin;
        int          n;
        build(ptr_now, fin);
        got_q.delete();
        xfer(1'b1, REG_CTRL, 8'h01, rd);
        if (poke) begin
            xfer(1'b0, REG_STATUS, 8'h00, rd);
            check(32'(rd[STAT_BUSY_BIT]), 32'h00000001);
            xfer(1'b1, SLOT_END, 8'h55, rd);
        end
        n = 0;
        do begin
            xfer(1'b0, REG_STATUS, 8'h00, rd);
            n++;
        end while (rd[STAT_DONE_BIT] !== 1'b1 && n < 3000);
        check(32'(rd[STAT_DONE_BIT]), 32'h00000001);
        // let the buffered bytes drain to the eeprom
        repeat (64) @(posedge clk);
        check(32'(got_q.size()), 32'(exp_q.size()));
        foreach (exp_q[k]) check({8'h00, got_q[k]}, {8'h00, exp_q[k]});
        rd_chk(REG_PTR_LO, fin[7:0]);
        rd_chk(REG_PTR_HI, fin[15:8]);
        ptr_now = fin;
    endtask

    // watchdog
    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        print_verdict();
    end

    initial begin
        error_cnt = 0;
        n_tests = 0;
        rst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 14'h0000;
        avs_writedata = 32'h00000000;
        ptr_now = 16'h0000;
        slot = '{RST_U1_INSTR, RST_U1_ADDR_A, RST_U1_ADDR_B, RST_U2_INSTR, RST_U2_ADDR_A,
                 RST_U2_ADDR_B, RST_U3_INSTR, RST_U3_ADDR_A, RST_U3_ADDR_B, RST_END};
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // slot defaults, unmapped place, pointer at zero
        for (int i = 0; i < SLOT_COUNT; i++) rd_chk(SLOT_U1_INSTR + 12'(i), slot[i]);
        rd_chk(12'hE6F, 8'h00);
        rd_chk(REG_PTR_LO, 8'h00);
        $display("test reset_values done");
        run_seq(1'b0);
        $display("test default_store done");
        // shortest and longest counts, pause, slot write while busy
        wr_slot(0, 8'h00);
        wr_slot(1, 8'h12);
        wr_slot(2, 8'h34);
        wr_slot(3, INSTR_DATA_MAX);
        wr_slot(6, INSTR_PAUSE);
        rd_chk(SLOT_U1_ADDR_A, 8'h12);
        run_seq(1'b1);
        rd_chk(SLOT_END, RST_END);
        $display("test pause_store done");
        // resume from the advanced pointer
        wr_slot(6, RST_U3_INSTR);
        run_seq(1'b0);
        $display("test resume_store done");
        print_verdict();
    end
endmodule // eeprom_store_sequence_pll_ops_test
